// ---- core/rmh_pkg.sv ----
package rmh_pkg;
	localparam int NAX = 5;
	localparam int NWORD = 10;
	localparam int MODE_W = 2;
	localparam int SLOT_W = 3;
	localparam int FW = 19;
	localparam logic [7:0] A_STEP = 8'h04;
	localparam logic [7:0] A_DIR = 8'h00;
	localparam logic [7:0] A_ORDER = 8'h04;
	localparam logic [7:0] A_MODE = 8'h08;
	localparam logic [7:0] A_CTRL = 8'h0C;
	localparam logic [7:0] A_FFOVR = 8'h10;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam logic [7:0] A_FEED = 8'h40;
	localparam logic [7:0] A_LEAVE = 8'h60;
	localparam logic [4:0] RST_DIR = 5'h00;
	localparam logic [14:0] RST_ORDER = 15'h58D1;
	localparam logic [9:0] RST_MODE = 10'h155;
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [4:0] RST_FFOVR = 5'h00;
	localparam logic [FW-1:0] RST_FEED = 19'h02710;
	localparam logic [FW-1:0] RST_LEAVE = 19'h000C8;
	localparam logic [FW-1:0] FEED_MIN = 19'h0000A;
	localparam logic [FW-1:0] FEED_MAX = 19'h493E0;
	localparam logic [2:0] SLOT_END = 3'h5;
	localparam logic [3:0] LEAVE_BASE = 4'h5;
	localparam int CTRL_GLOBAL = 0;
	localparam int CTRL_OPM = 1;
	localparam int STAT_HOMED = 1;
	localparam int STAT_AXIS = 6;
	localparam int STAT_STATE = 9;
	localparam logic [3:0] STRB_ALL = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {APPR_DC1, APPR_SINGLE, APPR_ROTARY, APPR_DC2} rmh_appr_t;
	typedef enum logic [1:0] {OPM_MANUAL, OPM_MDI, OPM_SINGLE, OPM_FULL} rmh_opm_t;
	typedef struct packed {
		logic awvalid; logic [7:0] awaddr;
		logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
		logic bready;
		logic arvalid; logic [7:0] araddr;
		logic rready;
	} rmh_axi_req_t;
	typedef struct packed {
		logic awready; logic wready;
		logic bvalid; logic [1:0] bresp;
		logic arready;
		logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} rmh_axi_rsp_t;
	typedef struct packed {
		logic key_start; logic [4:0] key_neg; logic [4:0] key_pos;
		logic [4:0] still; logic [4:0] beyond; logic [4:0] refm; logic [4:0] cam;
	} rmh_pins_t;
	typedef struct packed {
		logic [4:0] run; logic dir_neg; logic [FW-1:0] feed; logic [4:0] ff_sel;
	} rmh_drive_t;
endpackage

// ---- core/rmh_feed_mem.sv ----
`timescale 1ns/10ps
module rmh_feed_mem
	import rmh_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [3:0] waddr,
	input wire logic [rmh_pkg::FW-1:0] wdata,
	input wire logic [3:0] ra_addr,
	output logic [rmh_pkg::FW-1:0] ra_data,
	input wire logic [3:0] rb_addr,
	output logic [rmh_pkg::FW-1:0] rb_data
);
	typedef struct packed {
		logic [NWORD-1:0][FW-1:0] mem; logic [FW-1:0] ra; logic [FW-1:0] rb;
	} rmh_mem_t;
	function automatic rmh_mem_t init_val();
		rmh_mem_t r;
		r = '0;
		for (int i = 0; i < NWORD; i++) r.mem[i] = (i < NAX) ? RST_FEED : RST_LEAVE;
		return r;
	endfunction
	localparam rmh_mem_t MEM_INIT = init_val();
	rmh_mem_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (we && waddr < 4'(NWORD)) s_d.mem[waddr] = wdata;
		s_d.ra = (ra_addr < 4'(NWORD)) ? s_q.mem[ra_addr] : '0;
		s_d.rb = (rb_addr < 4'(NWORD)) ? s_q.mem[rb_addr] : '0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) s_q <= MEM_INIT;
		else s_q <= s_d;
	end
	assign ra_data = s_q.ra;
	assign rb_data = s_q.rb;
endmodule

// ---- core/rmh_axi_slave.sv ----
`timescale 1ns/10ps
module rmh_axi_slave
	import rmh_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire rmh_pkg::rmh_axi_req_t req,
	output rmh_pkg::rmh_axi_rsp_t rsp,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	typedef struct packed {
		logic aw_h; logic [7:0] awaddr; logic w_h; logic [31:0] wdata; logic [3:0] wstrb;
		logic bvalid; logic [1:0] bresp; logic [1:0] rcnt; logic [7:0] araddr;
		logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} rmh_slv_t;
	rmh_slv_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		rsp.bvalid = s_q.bvalid;
		rsp.bresp = s_q.bresp;
		rsp.rvalid = s_q.rvalid;
		rsp.rdata = s_q.rdata;
		rsp.rresp = s_q.rresp;
		rsp.awready = !s_q.aw_h && !s_q.bvalid;
		rsp.wready = !s_q.w_h && !s_q.bvalid;
		rsp.arready = (s_q.rcnt == 2'h0) && !s_q.rvalid;
		wr_en = s_q.aw_h && s_q.w_h;
		if (req.awvalid && rsp.awready) begin
			s_d.aw_h = 1'b1;
			s_d.awaddr = req.awaddr;
		end
		if (req.wvalid && rsp.wready) begin
			s_d.w_h = 1'b1;
			s_d.wdata = req.wdata;
			s_d.wstrb = req.wstrb;
		end
		if (wr_en) begin
			s_d.aw_h = 1'b0;
			s_d.w_h = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (s_q.bvalid && req.bready) s_d.bvalid = 1'b0;
		if (req.arvalid && rsp.arready) begin
			s_d.rcnt = 2'h1;
			s_d.araddr = req.araddr;
		end
		if (s_q.rcnt == 2'h1) s_d.rcnt = 2'h2;
		if (s_q.rcnt == 2'h2) begin
			s_d.rcnt = 2'h0;
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_err ? '0 : rd_data;
			s_d.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (s_q.rvalid && req.rready) s_d.rvalid = 1'b0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) s_q <= '0;
		else s_q <= s_d;
	end
	assign wr_addr = s_q.awaddr;
	assign wr_data = s_q.wdata;
	assign wr_strb = s_q.wstrb;
	assign rd_addr = s_q.araddr;
endmodule

// ---- core/rmh_homing_seq.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// What this block does
// [R1] Direction mask bit set means negative
// [R2] Homing feed per axis, 10 to 300000
// [R3] Reduced leaving feed only in mode 2
// [R4] Five order slots, 0 skips, default n
// [R5] Approach mode code per axis, 0 to 3
// [R6] Manual keys or start key, no code
// [R7] Controller routes cam trigger to marker
// [R8] Mode 0: cam at start reverses
// [R9] Mode 0: later cam ignored
// [R10] Mode 0: return to software limit
// [R11] Mode 1: cam always reverses direction
// [R12] Mode 1: start inside cam reverses
// [R13] Mode 2: onto cam, back slowly
// [R14] Mode 2: first mark after cam, stop
// [R15] Mode 2: start inside cam, slow reverse
// [R16] Mode 3: cam reverses at once
// [R17] Global selector: feed-forward or trailing, ignored in manual mode
// [R18] Per-axis bit forces feed-forward
// [R19] Slots homed strictly one after another
module rmh_homing_seq
	import rmh_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire rmh_pkg::rmh_axi_req_t axi_req,
	output rmh_pkg::rmh_axi_rsp_t axi_rsp,
	input wire rmh_pkg::rmh_pins_t pins,
	output rmh_pkg::rmh_drive_t drive
);
	import rmh_pkg::*;
	typedef enum logic [2:0] {
		ST_IDLE, ST_PICK, ST_START, ST_APPROACH, ST_LEAVE, ST_RETURN, ST_STOP
	} rmh_state_t;
	typedef struct packed {
		rmh_pins_t s1; rmh_pins_t s2; rmh_pins_t s3;
		logic [4:0] dir; logic [14:0] order; logic [9:0] mode;
		logic [2:0] ctrl; logic [4:0] ffovr;
		rmh_state_t st; logic autom; logic man_neg;
		logic [2:0] slot; logic [2:0] ax;
		logic dneg; logic reduced; logic left;
		logic [4:0] homed; logic [4:0] run; logic [4:0] ff_sel;
	} rmh_core_t;
	rmh_core_t s_q, s_d;
	logic wr_en, wr_err, rd_err, mem_we;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb, mem_waddr, mem_raddr, mem_rbaddr;
	logic [FW-1:0] mem_wdata, mem_rdata, mem_rbdata;
	logic cam, cam_rise, mark, beyond, still, base, start_rise;
	logic [4:0] key_rise_p, key_rise_n;
	logic [4:0] fw_wr, fw_rd;
	logic [31:0] mw;
	logic [2:0] code;
	rmh_appr_t ap;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) if (b[i]) r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction
	function automatic logic [4:0] feed_word(input logic [7:0] a);
		logic [4:0] r;
		r = '0;
		for (int i = 0; i < NAX; i++) begin
			if (a == A_FEED + 8'(i) * A_STEP) r = {1'b1, 4'(i)};
			if (a == A_LEAVE + 8'(i) * A_STEP) r = {1'b1, LEAVE_BASE + 4'(i)};
		end
		return r;
	endfunction
	function automatic logic [FW-1:0] clamp_feed(input logic [31:0] v);
		logic [FW-1:0] r;
		if (v < 32'(FEED_MIN)) r = FEED_MIN;
		else if (v > 32'(FEED_MAX)) r = FEED_MAX;
		else r = v[FW-1:0];
		return r;
	endfunction
	function automatic rmh_appr_t mode_of(input logic [9:0] m, input logic [2:0] a);
		rmh_appr_t r;
		r = rmh_appr_t'(m[MODE_W-1:0]);
		for (int i = 0; i < NAX; i++) if (a == 3'(i)) r = rmh_appr_t'(m[i*MODE_W +: MODE_W]); // R5
		return r;
	endfunction
	function automatic logic [2:0] slot_code(input logic [14:0] o, input logic [2:0] sl);
		logic [2:0] r;
		r = '0;
		for (int i = 0; i < NAX; i++) if (sl == 3'(i)) r = o[i*SLOT_W +: SLOT_W];
		return r;
	endfunction
	function automatic logic reg_known(input logic [7:0] a);
		logic [4:0] f;
		f = feed_word(a);
		return a == A_DIR || a == A_ORDER || a == A_MODE || a == A_CTRL || a == A_FFOVR
			|| a == A_STAT || f[4];
	endfunction

	rmh_axi_slave u_slave (
		.clk(clk),
		.rst(rst),
		.req(axi_req),
		.rsp(axi_rsp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);
	rmh_feed_mem u_mem (
		.clk(clk),
		.rst(rst),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.ra_addr(mem_raddr),
		.ra_data(mem_rdata),
		.rb_addr(mem_rbaddr),
		.rb_data(mem_rbdata)
	);

	// Feed words take only full-word writes, clamped into range
	assign wr_err = !reg_known(wr_addr) || wr_addr == A_STAT;
	assign rd_err = !reg_known(rd_addr);
	assign fw_wr = feed_word(wr_addr);
	assign fw_rd = feed_word(rd_addr);
	assign mem_waddr = fw_wr[3:0];
	assign mem_we = wr_en && fw_wr[4] && wr_strb == STRB_ALL;
	assign mem_wdata = clamp_feed(wr_data); // R2
	assign mem_raddr = fw_rd[3:0];
	assign mem_rbaddr = s_q.reduced ? LEAVE_BASE + 4'(s_q.ax) : 4'(s_q.ax); // R3

	always_comb begin
		if (rd_addr == A_DIR) rd_data = 32'(s_q.dir);
		else if (rd_addr == A_ORDER) rd_data = 32'(s_q.order);
		else if (rd_addr == A_MODE) rd_data = 32'(s_q.mode);
		else if (rd_addr == A_CTRL) rd_data = 32'(s_q.ctrl);
		else if (rd_addr == A_FFOVR) rd_data = 32'(s_q.ffovr);
		else if (rd_addr == A_STAT) rd_data = 32'({s_q.st, s_q.ax, s_q.homed, s_q.st != ST_IDLE});
		else if (fw_rd[4]) rd_data = 32'(mem_rdata);
		else rd_data = '0;
	end

	// Cam markers come from the controller through free inputs
	assign cam = s_q.s2.cam[s_q.ax]; // R7
	assign cam_rise = cam && !s_q.s3.cam[s_q.ax];
	assign mark = s_q.s2.refm[s_q.ax] && !s_q.s3.refm[s_q.ax];
	assign beyond = s_q.s2.beyond[s_q.ax];
	assign still = s_q.s2.still[s_q.ax];
	assign start_rise = s_q.s2.key_start && !s_q.s3.key_start;
	assign key_rise_p = s_q.s2.key_pos & ~s_q.s3.key_pos;
	assign key_rise_n = s_q.s2.key_neg & ~s_q.s3.key_neg;
	assign ap = mode_of(s_q.mode, s_q.ax);
	assign code = slot_code(s_q.order, s_q.slot);
	assign base = s_q.autom ? s_q.dir[s_q.ax] : s_q.man_neg; // R1

	always_comb begin
		s_d = s_q;
		mw = '0;
		s_d.s1 = pins;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		if (wr_en) begin
			if (wr_addr == A_DIR) begin
				mw = merge(32'(s_q.dir), wr_data, wr_strb);
				s_d.dir = mw[4:0]; // R1
			end else if (wr_addr == A_ORDER) begin
				mw = merge(32'(s_q.order), wr_data, wr_strb);
				s_d.order = mw[14:0]; // R4
			end else if (wr_addr == A_MODE) begin
				mw = merge(32'(s_q.mode), wr_data, wr_strb);
				s_d.mode = mw[9:0]; // R5
			end else if (wr_addr == A_CTRL) begin
				mw = merge(32'(s_q.ctrl), wr_data, wr_strb);
				s_d.ctrl = mw[2:0]; // R17
			end else if (wr_addr == A_FFOVR) begin
				mw = merge(32'(s_q.ffovr), wr_data, wr_strb);
				s_d.ffovr = mw[4:0]; // R18
			end
		end
		case (s_q.st)
			ST_IDLE: begin
				if (start_rise) begin
					s_d.autom = 1'b1; // R6
					s_d.slot = '0;
					s_d.homed = '0;
					s_d.st = ST_PICK;
				end else if ((key_rise_p | key_rise_n) != 5'h00) begin
					s_d.autom = 1'b0; // R6
					for (int i = NAX - 1; i >= 0; i--) begin
						if (key_rise_p[i] || key_rise_n[i]) begin
							s_d.ax = 3'(i);
							s_d.man_neg = key_rise_n[i];
						end
					end
					s_d.st = ST_START;
				end
			end
			ST_PICK: begin
				if (s_q.slot >= SLOT_END) s_d.st = ST_IDLE;
				else if (code == 3'h0 || code > 3'(NAX)) s_d.slot = s_q.slot + 3'h1; // R4
				else begin
					s_d.ax = code - 3'h1;
					s_d.st = ST_START;
				end
			end
			ST_START: begin
				s_d.left = 1'b0;
				if (cam) begin
					s_d.dneg = !base; // R8 R12 R15
					s_d.reduced = (ap == APPR_ROTARY); // R15
					s_d.st = (ap == APPR_ROTARY) ? ST_LEAVE : ST_APPROACH;
				end else begin
					s_d.dneg = base;
					s_d.reduced = 1'b0;
					s_d.st = ST_APPROACH;
				end
			end
			ST_APPROACH: begin
				if (cam_rise && ap != APPR_DC1) begin // R9
					if (ap == APPR_SINGLE) s_d.dneg = !s_q.dneg; // R11
					else if (ap == APPR_DC2) s_d.dneg = !base; // R16
					else begin
						s_d.dneg = !s_q.dneg; // R13
						s_d.reduced = 1'b1;
						s_d.left = 1'b0;
						s_d.st = ST_LEAVE;
					end
				end else if (mark && ap != APPR_ROTARY) begin
					if (ap == APPR_DC1 && beyond) begin
						s_d.dneg = !s_q.dneg; // R10
						s_d.st = ST_RETURN;
					end else s_d.st = ST_STOP;
				end
			end
			ST_LEAVE: begin
				if (!cam) s_d.left = 1'b1;
				if (mark && s_q.left) s_d.st = ST_STOP; // R14
			end
			ST_RETURN: begin
				if (!beyond) s_d.st = ST_STOP; // R10
			end
			ST_STOP: begin
				s_d.reduced = 1'b0;
				if (still) begin
					s_d.homed[s_q.ax] = 1'b1;
					if (s_q.autom) begin
						s_d.slot = s_q.slot + 3'h1; // R19
						s_d.st = ST_PICK;
					end else s_d.st = ST_IDLE;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		if (s_d.st == ST_APPROACH || s_d.st == ST_LEAVE || s_d.st == ST_RETURN)
			s_d.run = 5'h01 << s_d.ax; // R19
		else s_d.run = '0;
		if (s_q.ctrl[CTRL_OPM +: 2] != 2'(OPM_MANUAL) && !s_q.ctrl[CTRL_GLOBAL])
			s_d.ff_sel = 5'h1F; // R17
		else s_d.ff_sel = s_q.ffovr; // R18
		s_d.ff_sel = s_d.ff_sel | s_q.ffovr; // R18
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.dir <= RST_DIR;
			s_q.order <= RST_ORDER;
			s_q.mode <= RST_MODE;
			s_q.ctrl <= RST_CTRL;
			s_q.ffovr <= RST_FFOVR;
			s_q.st <= ST_IDLE;
		end else s_q <= s_d;
	end

	assign drive.run = s_q.run;
	assign drive.dir_neg = s_q.dneg;
	assign drive.feed = mem_rbdata;
	assign drive.ff_sel = s_q.ff_sel;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_dir_write: assert property (wr_en && wr_addr == A_DIR && wr_strb == STRB_ALL // R1
		|=> s_q.dir == $past(wr_data[4:0])) else $error("direction mask not written");
	a_feed_range: assert property (mem_we |-> mem_wdata >= FEED_MIN && mem_wdata <= FEED_MAX) // R2
		else $error("feed rate out of range");
	a_slow_mode2: assert property (s_q.reduced && s_q.run != 5'h00 |-> ap == APPR_ROTARY) // R3
		else $error("reduced feed outside mode 2");
	a_slot_skip: assert property (s_q.st == ST_PICK && s_q.slot < SLOT_END && code == 3'h0 // R4
		|=> s_q.st == ST_PICK && s_q.slot == $past(s_q.slot) + 3'h1) else $error("empty slot not skipped");
	a_manual_go: assert property (s_q.st == ST_IDLE && !start_rise && (key_rise_p | key_rise_n) != 5'h00 // R6
		|=> s_q.st == ST_START && !s_q.autom ##1 s_q.run != 5'h00) else $error("manual homing not started");
	a_dc1_start: assert property (s_q.st == ST_START && ap == APPR_DC1 && cam // R8
		|=> s_q.dneg == !$past(base) && s_q.st == ST_APPROACH) else $error("mode 0 start direction wrong");
	a_dc1_ignore: assert property (s_q.st == ST_APPROACH && ap == APPR_DC1 && cam_rise && !mark // R9
		|=> s_q.dneg == $past(s_q.dneg) && s_q.st == ST_APPROACH) else $error("mode 0 late cam acted on");
	a_dc1_return: assert property (s_q.st == ST_APPROACH && ap == APPR_DC1 && mark && beyond // R10
		|=> s_q.st == ST_RETURN && s_q.dneg != $past(s_q.dneg)) else $error("no return to limit");
	a_single_rev: assert property (s_q.st == ST_APPROACH && ap == APPR_SINGLE && cam_rise // R11
		|=> s_q.dneg != $past(s_q.dneg)) else $error("mode 1 did not reverse");
	a_single_in: assert property (s_q.st == ST_START && ap == APPR_SINGLE && cam // R12
		|=> s_q.dneg == !$past(base)) else $error("mode 1 start in cam wrong");
	a_rot_cam: assert property (s_q.st == ST_APPROACH && ap == APPR_ROTARY && cam_rise // R13
		|=> s_q.st == ST_LEAVE && s_q.reduced && s_q.dneg != $past(s_q.dneg)) else $error("mode 2 no slow reverse");
	a_rot_stop: assert property (s_q.st == ST_LEAVE && s_q.left && mark // R14
		|=> s_q.st == ST_STOP && s_q.run == 5'h00) else $error("mode 2 did not stop");
	a_rot_in: assert property (s_q.st == ST_START && ap == APPR_ROTARY && cam // R15
		|=> s_q.st == ST_LEAVE && s_q.reduced && s_q.dneg == !$past(base)) else $error("mode 2 start in cam wrong");
	a_dc2_rev: assert property (s_q.st == ST_APPROACH && ap == APPR_DC2 && cam_rise // R16
		|=> s_q.dneg == !$past(base)) else $error("mode 3 did not reverse");
	a_ctrl_type: assert property (##1 (s_q.ctrl[CTRL_OPM +: 2] != 2'(OPM_MANUAL) && !s_q.ctrl[CTRL_GLOBAL]) // R17
		|=> s_q.ff_sel == 5'h1F) else $error("feed-forward not selected");
	a_ovr_force: assert property (##1 1'b1 |=> (s_q.ff_sel & $past(s_q.ffovr)) == $past(s_q.ffovr)) // R18
		else $error("override bit not forcing feed-forward");
	a_one_axis: assert property ($onehot0(s_q.run) && (s_q.st != ST_STOP || s_q.run == 5'h00)) // R19
		else $error("more than one axis moving");
	c_auto_run: cover property (s_q.st == ST_STOP && s_q.autom ##1 s_q.st == ST_PICK);
	c_rot_leave: cover property (s_q.st == ST_LEAVE && s_q.left ##1 s_q.st == ST_STOP);
	c_return: cover property (s_q.st == ST_RETURN ##1 s_q.st == ST_STOP);
endmodule

// ---- verification/rmh_axis_model.sv ----
`timescale 1ns/10ps
// Axis drives with encoders: one step per cycle while run, marks at +20 and -70
module rmh_axis_model
	import rmh_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire rmh_pkg::rmh_drive_t drive,
	input wire logic ld,
	input wire logic signed [7:0] ld_pos,
	input wire logic [4:0] cam_force,
	input wire logic slow,
	output logic [4:0] cam,
	output logic [4:0] refm,
	output logic [4:0] beyond,
	output logic [4:0] still
);
	logic signed [7:0] pos_q [NAX];
	logic [3:0] idle_q [NAX];
	always_ff @(posedge clk or posedge rst) begin
		for (int i = 0; i < NAX; i++) begin
			if (rst) begin
				pos_q[i] <= 8'sh00;
				idle_q[i] <= 4'h0;
			end else begin
				if (ld) begin
					pos_q[i] <= ld_pos;
				end else if (drive.run[i]) begin
					pos_q[i] <= drive.dir_neg ? pos_q[i] - 8'sh01 : pos_q[i] + 8'sh01;
				end
				idle_q[i] <= drive.run[i] ? 4'h0 : (idle_q[i] == 4'hF ? idle_q[i] : idle_q[i] + 4'h1);
			end
		end
	end
	always_comb begin
		for (int i = 0; i < NAX; i++) begin
			cam[i] = pos_q[i] >= 8'sh28 || cam_force[i];
			refm[i] = pos_q[i] == 8'sh14 || pos_q[i] == -8'sh46;
			beyond[i] = pos_q[i] > 8'sh3C || pos_q[i] < -8'sh3C;
			still[i] = idle_q[i] >= (slow ? 4'h8 : 4'h1);
		end
	end
endmodule

// ---- verification/test_rmh_homing_seq.sv ----
`timescale 1ns/10ps
module test_rmh_homing_seq import rmh_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	rmh_axi_req_t req = '0;
	rmh_axi_rsp_t rsp;
	rmh_pins_t pins;
	rmh_drive_t drive;
	logic key_start = 1'b0;
	logic [4:0] key_neg = 5'h00;
	logic [4:0] key_pos = 5'h00;
	logic ld = 1'b0;
	logic signed [7:0] ld_pos = 8'sh00;
	logic [4:0] cam_force = 5'h00;
	logic slow = 1'b0;
	logic [4:0] cam;
	logic [4:0] refm;
	logic [4:0] beyond;
	logic [4:0] still;
	int errors = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	assign pins = {key_start, key_neg, key_pos, still, beyond, refm, cam};
	rmh_homing_seq i_rmh_homing_seq (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .pins(pins),
		.drive(drive));
	rmh_axis_model i_rmh_axis_model (.clk(clk), .rst(rst), .drive(drive), .ld(ld), .ld_pos(ld_pos),
		.cam_force(cam_force), .slow(slow), .cam(cam), .refm(refm), .beyond(beyond), .still(still));

	task automatic stop_test;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic wr_raw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= STRB_ALL;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready === 1'b1 && req.awvalid === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1 && req.wvalid === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr_raw(a, d, r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready === 1'b1 && req.arvalid === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
	endtask

	task automatic wait_mv(input bit on);
		int n = 0;
		while (((drive.run === 5'h00) == on) && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic wait_dir(input logic v);
		int n = 0;
		while (drive.dir_neg !== v && n < 300) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic settle;
		logic [31:0] d = 32'h1;
		logic [1:0] r;
		int n = 0;
		wait_mv(0);
		while (d[0] !== 1'b0 && n < 40) begin
			rd(A_STAT, d, r);
			n++;
		end
	endtask

	task automatic home(input logic [31:0] mode, input logic signed [7:0] p);
		wr(A_MODE, mode);
		ld_pos <= p;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		key_start <= 1'b1;
		repeat (2) @(posedge clk);
		key_start <= 1'b0;
		wait_mv(1);
	endtask

	task automatic t_regs;
		logic [7:0] ad [7] = '{A_DIR, A_ORDER, A_MODE, A_CTRL, A_FFOVR, A_FEED, A_LEAVE + 8'h10};
		logic [31:0] ex [7] = '{32'h0, 32'h58D1, 32'h155, 32'h0, 32'h0, 32'h2710, 32'hC8};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 7; i++) begin
			rd(ad[i], d, r);
			chk("reset value", ex[i], d);
		end
		rd(8'h30, d, r);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		wr_raw(A_STAT, 32'h1, r);
		chk("status bresp", 32'(RESP_SLVERR), 32'(r));
		wr(A_FEED + 8'h04, 32'h5);
		rd(A_FEED + 8'h04, d, r);
		chk("feed low clamp", 32'hA, d);
		wr(A_FEED + 8'h04, 32'h7FFFF);
		rd(A_FEED + 8'h04, d, r);
		chk("feed high clamp", 32'h493E0, d);
		wr(A_ORDER, 32'h1);
		wr(A_FEED, 32'h4D2);
		wr(A_LEAVE, 32'h4D);
	endtask

	task automatic t_ffsel;
		wr(A_FFOVR, 32'h05);
		for (int m = 0; m < 4; m++) begin
			for (int g = 0; g < 2; g++) begin
				wr(A_CTRL, 32'(m * 2 + g));
				repeat (3) @(posedge clk);
				chk("ff_sel", (m != 0 && g == 0) ? 32'h1F : 32'h05, 32'(drive.ff_sel));
			end
		end
		wr(A_FFOVR, 32'h0);
		wr(A_CTRL, 32'h0);
	endtask

	task automatic t_cam_start;
		for (int m = 0; m < 4; m++) begin
			home(32'(m), 8'sh32);
			repeat (4) @(posedge clk);
			chk("dir from cam", 32'h1, 32'(drive.dir_neg));
			chk("feed", m == 2 ? 32'h4D : 32'h4D2, 32'(drive.feed));
			settle;
		end
	endtask

	task automatic t_cam_mid;
		int ms [3] = '{0, 1, 3};
		foreach (ms[k]) begin
			home(32'(ms[k]), 8'sh00);
			repeat (6) @(posedge clk);
			cam_force <= 5'h01;
			repeat (8) @(posedge clk);
			chk("dir after cam", ms[k] == 0 ? 32'h0 : 32'h1, 32'(drive.dir_neg));
			cam_force <= 5'h00;
			settle;
		end
	endtask

	task automatic t_mode2;
		logic signed [7:0] p;
		home(32'h2, 8'sh00);
		repeat (3) @(posedge clk);
		chk("approach feed", 32'h4D2, 32'(drive.feed));
		wait_dir(1'b1);
		chk("leave run", 32'h1, 32'(drive.run));
		repeat (3) @(posedge clk);
		chk("leave feed", 32'h4D, 32'(drive.feed));
		settle;
		p = i_rmh_axis_model.pos_q[0];
		chk("stop after mark", 32'h1, 32'(p <= 8'sh14 && p > 8'sh0A));
	endtask

	task automatic t_beyond;
		wr(A_DIR, 32'h1);
		home(32'h0, -8'sh32);
		repeat (2) @(posedge clk);
		chk("mask dir", 32'h1, 32'(drive.dir_neg));
		wait_dir(1'b0);
		chk("return run", 32'h1, 32'(drive.run));
		settle;
		chk("inside limit", 32'h0, 32'(beyond[0]));
		wr(A_DIR, 32'h0);
	endtask

	task automatic t_order;
		logic [31:0] d;
		logic [1:0] r;
		int n = 0;
		wr(A_ORDER, 32'h6043);
		slow <= 1'b1;
		home(32'h0, 8'sh00);
		chk("first slot", 32'h04, 32'(drive.run));
		wait_mv(0);
		while (drive.run === 5'h00 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("waits for still", 32'h1, 32'(n >= 8));
		chk("next slot", 32'h01, 32'(drive.run));
		settle;
		rd(A_STAT, d, r);
		chk("homed axes", 32'h05, 32'(d[5:1]));
		slow <= 1'b0;
		wr(A_ORDER, 32'h1);
	endtask

	task automatic t_manual;
		wr(A_MODE, 32'h4);
		ld_pos <= 8'sh00;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		key_neg <= 5'h02;
		repeat (2) @(posedge clk);
		key_neg <= 5'h00;
		wait_mv(1);
		chk("manual axis", 32'h02, 32'(drive.run));
		chk("manual dir", 32'h1, 32'(drive.dir_neg));
		key_pos <= 5'h08;
		repeat (2) @(posedge clk);
		key_pos <= 5'h00;
		repeat (4) @(posedge clk);
		chk("key while busy", 32'h02, 32'(drive.run));
		settle;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_ffsel;
		t_cam_start;
		t_cam_mid;
		t_mode2;
		t_beyond;
		t_order;
		t_manual;
		stop_test;
	end

	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		stop_test;
	end
endmodule
